// ### hdl/stop_brake_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef STOP_BRAKE_REGS_VH
`define STOP_BRAKE_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONFIG       8'h00
`define OFS_STATUS       8'h04
`define OFS_INT_STATUS   8'h08
`define OFS_INT_MASK     8'h0c

// ----------------------------------------------------------------
// Config fields
// ----------------------------------------------------------------
`define CFG_HOLD_LSB     0
`define CFG_ABORT_BIT    2
`define CFG_GUARD_BIT    3
`define CFG_REFGATE_BIT  4
`define CFG_LIFTSRC_BIT  5
`define CFG_METRIC_BIT   6
`define CFG_WIDTH        7

// Hold source encodings
`define HOLD_TERMINAL    2'h0
`define HOLD_RUN_LOGIC   2'h1
`define HOLD_SERIAL      2'h2

// Reset config: terminal hold, English units defaults, fault, internal
`define CFG_RESET        7'h00
// Metric strap sets abort enable, reference gate and the metric bit
`define CFG_METRIC_SET   7'h54

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define INT_FAULT_BIT    0
`define INT_ALARM_BIT    1
`define INT_STOP_BIT     2
`define INT_WIDTH        3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    32'h0000_0004
`define DB_GRACE_S       32'h0000_000a
`define NS_PER_S         32'h3b9a_ca00
// Ten seconds of 4 ns cycles is 2500000000: past signed integer range, held only as 32-bit unsigned
`define DB_GRACE_CYCLES  (`DB_GRACE_S * (`NS_PER_S / `CLK_PERIOD_NS))

`endif

// ### hdl/drive_stop_brake_sequencer.v
// Stop, speed reference and brake sequencing with braking switch guard
// Summary of operation
// - Run-logic hold keeps internal run until torque ramp-down stop completes.
// - Abort enable bit for profile generator; off in English, on in metric.
// - Braking switch only while regulator released, plus post-stop grace.
// - Braking switch allowed at most ten seconds after running ends.
// - Switch still on at expiry: force off, raise braking overvoltage event.
// - Guard bit reports the overvoltage event as fault or alarm; fault default.
// - Follow mode: reference release asserted together with regulator release.
// - Brake mode: reference release held until brake-lifted indication true.
// - Internal lift source requests lift on magnetizing current, else serial.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "stop_brake_regs.vh"

module drive_stop_brake_sequencer #(
    parameter [31:0] DB_GRACE_CYCLES = `DB_GRACE_CYCLES
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Unit strap, sampled after reset release
    input  wire        metric_units,
    // Drive pins from controller and drive core
    input  wire        run_terminal,
    input  wire        run_serial,
    input  wire        ramp_down_active,
    input  wire        reg_release,
    input  wire        mag_current_ok,
    input  wire        brake_lifted,
    input  wire        lift_serial,
    input  wire        db_demand,
    // Drive outputs
    output reg         run_internal,
    output reg         spd_ref_release,
    output reg         brake_lift_req,
    output reg         db_switch,
    output reg         fault_out,
    output reg         alarm_out,
    output reg         curve_abort_en,
    output reg         irq,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    reg [9:0] meta_reg;
    reg [9:0] sync_reg;
    reg       strap_done_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 10'h000;
            sync_reg <= 10'h000;
        end else begin
            // Bit 0 marks when sync holds real pin data, not reset zeros
            meta_reg <= {metric_units, run_terminal, run_serial,
                         ramp_down_active, reg_release, mag_current_ok,
                         brake_lifted, lift_serial, db_demand, 1'b1};
            sync_reg <= meta_reg;
        end
    end
    wire s_metric  = sync_reg[9];
    wire s_run_tb  = sync_reg[8];
    wire s_run_ser = sync_reg[7];
    wire s_ramp    = sync_reg[6];
    wire s_reg_rel = sync_reg[5];
    wire s_mag     = sync_reg[4];
    wire s_brk_up  = sync_reg[3];
    wire s_lift_sr = sync_reg[2];
    wire s_db_dem  = sync_reg[1];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [`CFG_WIDTH-1:0] config_reg;
    reg  [`INT_WIDTH-1:0] int_status_reg;
    reg  [`INT_WIDTH-1:0] int_mask_reg;
    wire [1:0] hold_src  = config_reg[`CFG_HOLD_LSB+1:`CFG_HOLD_LSB];
    wire guard_alarm     = config_reg[`CFG_GUARD_BIT];
    wire gate_on_brake   = config_reg[`CFG_REFGATE_BIT];
    wire lift_from_ser   = config_reg[`CFG_LIFTSRC_BIT];

    // ----------------------------------------------------------------
    // Run hold
    // ----------------------------------------------------------------
    // External run command from whichever source is configured
    wire ext_run = (hold_src == `HOLD_SERIAL) ? s_run_ser : s_run_tb;
    // Run-logic hold stretches run over the ramp-down
    wire run_next = ext_run ||
                    ((hold_src == `HOLD_RUN_LOGIC) && run_internal &&
                     s_ramp);

    // ----------------------------------------------------------------
    // Braking switch guard
    // ----------------------------------------------------------------
    reg  [31:0] grace_cnt_reg;
    reg         expired_reg;
    wire        grace_done = (grace_cnt_reg >= DB_GRACE_CYCLES - 32'h1);
    wire        db_allow   = s_reg_rel || !expired_reg;
    wire        trip       = !s_reg_rel && !expired_reg &&
                             grace_done && db_switch;
    wire        stop_edge  = run_internal && !run_next;

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    reg        aw_have_reg;
    reg        w_have_reg;
    reg [7:0]  aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                         {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [31:0] wval  = w_data_reg & wmask;
    wire wr_cfg  = do_write && aw_addr_reg == `OFS_CONFIG;
    wire wr_ints = do_write && aw_addr_reg == `OFS_INT_STATUS;
    wire wr_mask = do_write && aw_addr_reg == `OFS_INT_MASK;
    wire wr_ok   = wr_cfg || wr_ints || wr_mask ||
                   aw_addr_reg == `OFS_STATUS;

    // Byte address forced to a word boundary; sub-word bits ignored
    function [7:0] word_addr;
        input [7:0] addr;
        begin
            word_addr = {addr[7:2], 2'h0};
        end
    endfunction

    function [31:0] read_word;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_CONFIG:     read_word = {25'h0, config_reg};
                `OFS_STATUS:     read_word = {25'h0, expired_reg,
                                    db_switch, brake_lift_req,
                                    spd_ref_release, run_internal,
                                    fault_out, alarm_out};
                `OFS_INT_STATUS: read_word = {29'h0, int_status_reg};
                `OFS_INT_MASK:   read_word = {29'h0, int_mask_reg};
                default:         read_word = 32'h0000_0000;
            endcase
        end
    endfunction

    function addr_ok;
        input [7:0] addr;
        begin
            addr_ok = (addr == `OFS_CONFIG) || (addr == `OFS_STATUS) ||
                      (addr == `OFS_INT_STATUS) ||
                      (addr == `OFS_INT_MASK);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h0000_0000;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready &&
                             s_axi_awvalid;
            s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= word_addr(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                             s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= read_word(word_addr(s_axi_araddr));
                s_axi_rresp  <= addr_ok(word_addr(s_axi_araddr)) ?
                                2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencing and guard state
    // ----------------------------------------------------------------
    // Events: trip as fault or alarm, and each completed stop
    wire [`INT_WIDTH-1:0] ev = {stop_edge, trip && guard_alarm,
                                trip && !guard_alarm};

    always @(posedge aclk) begin
        if (!aresetn) begin
            config_reg      <= `CFG_RESET;
            strap_done_reg  <= 1'b0;
            int_status_reg  <= {`INT_WIDTH{1'b0}};
            int_mask_reg    <= {`INT_WIDTH{1'b0}};
            run_internal    <= 1'b0;
            spd_ref_release <= 1'b0;
            brake_lift_req  <= 1'b0;
            db_switch       <= 1'b0;
            fault_out       <= 1'b0;
            alarm_out       <= 1'b0;
            curve_abort_en  <= 1'b0;
            irq             <= 1'b0;
            grace_cnt_reg   <= 32'h0;
            expired_reg     <= 1'b0;
        end else begin
            // Strap is caught once, when the fill marker reaches sync
            strap_done_reg <= strap_done_reg | sync_reg[0];
            if (!strap_done_reg && sync_reg[0] && s_metric) begin
                config_reg <= config_reg | `CFG_METRIC_SET;
            end else if (wr_cfg) begin
                config_reg <= wval[`CFG_WIDTH-1:0];
            end
            if (wr_mask) begin
                int_mask_reg <= wval[`INT_WIDTH-1:0];
            end
            // Set wins over a write-one clear in the same cycle
            int_status_reg <= (int_status_reg &
                               ~(wr_ints ? wval[`INT_WIDTH-1:0] :
                                 {`INT_WIDTH{1'b0}})) | ev;
            irq <= |(((int_status_reg | ev)) & int_mask_reg);

            run_internal   <= run_next;
            curve_abort_en <= config_reg[`CFG_ABORT_BIT];
            spd_ref_release <= s_reg_rel &&
                               (!gate_on_brake || s_brk_up);
            brake_lift_req  <= lift_from_ser ? s_lift_sr
                                             : s_mag;

            // Grace counter runs only while stopped
            if (s_reg_rel) begin
                grace_cnt_reg <= 32'h0;
                expired_reg   <= 1'b0;
            end else if (!expired_reg) begin
                if (grace_done) begin
                    expired_reg <= 1'b1;
                end else begin
                    grace_cnt_reg <= grace_cnt_reg + 32'h1;
                end
            end
            // Expiry forces switch off and keeps it off until next run
            db_switch <= s_db_dem && db_allow && !trip;
            // Fault and alarm both latch until running again
            if (trip && !guard_alarm) begin
                fault_out <= 1'b1;
            end else if (s_reg_rel) begin
                fault_out <= 1'b0;
            end
            if (trip && guard_alarm) begin
                alarm_out <= 1'b1;
            end else if (s_reg_rel) begin
                alarm_out <= 1'b0;
            end
        end
    end

endmodule

// ### test/stop_brake_monitor.sv
// Port-level assertions for the stop and brake sequencer
`timescale 1ns/1ps
module stop_brake_monitor #(
    parameter [31:0] DB_GRACE_CYCLES = 32'd20
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Drive inputs
    input wire run_terminal,
    input wire run_serial,
    input wire ramp_down_active,
    input wire reg_release,
    input wire mag_current_ok,
    input wire lift_serial,
    input wire db_demand,
    // Drive outputs
    input wire run_internal,
    input wire spd_ref_release,
    input wire brake_lift_req,
    input wire db_switch,
    input wire fault_out,
    input wire alarm_out,
    input wire curve_abort_en,
    input wire s_axi_bvalid
);
    reg [31:0] low_cnt_reg;
    reg [2:0]  age_reg;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Saturates so a long idle spell never wraps back to zero
    always @(posedge aclk) begin
        if (!aresetn || reg_release)
            low_cnt_reg <= 32'h0;
        else if (low_cnt_reg != 32'hffffffff)
            low_cnt_reg <= low_cnt_reg + 32'h1;
    end

    // Cycles since reset release; the unit strap lands at a fixed age
    always @(posedge aclk) begin
        if (!aresetn)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    end

    a_ref_after_reg: assert property (
        spd_ref_release |-> $past(reg_release, 3))
        else $error("Reference released without regulator release");
    a_db_on_demand: assert property (
        db_switch |-> $past(db_demand, 3))
        else $error("Braking switch on without demand");
    a_db_grace_limit: assert property (
        db_switch |-> low_cnt_reg < DB_GRACE_CYCLES + 32'd6)
        else $error("Braking switch on past the grace interval");
    a_trip_switch_off: assert property (
        $rose(fault_out) || $rose(alarm_out) |-> !db_switch)
        else $error("Overvoltage event while switch still on");
    a_one_event_kind: assert property (
        !(fault_out && alarm_out))
        else $error("Fault and alarm raised together");
    a_run_has_cause: assert property (
        run_internal |-> $past(run_terminal, 3) || $past(run_serial, 3)
            || $past(ramp_down_active, 3))
        else $error("Internal run without command or ramp-down");
    a_lift_has_cause: assert property (
        brake_lift_req |-> $past(mag_current_ok, 3) || $past(lift_serial, 3))
        else $error("Lift request without magnetizing or serial request");
    a_abort_by_write: assert property (
        $changed(curve_abort_en) |->
            $past(s_axi_bvalid) || s_axi_bvalid || age_reg == 3'h4)
        else $error("Abort enable changed without write or strap");
endmodule

bind drive_stop_brake_sequencer stop_brake_monitor #(
    .DB_GRACE_CYCLES(DB_GRACE_CYCLES)
) stop_brake_monitor_inst (
    .aclk(aclk), .aresetn(aresetn), .run_terminal(run_terminal),
    .run_serial(run_serial), .ramp_down_active(ramp_down_active),
    .reg_release(reg_release), .mag_current_ok(mag_current_ok),
    .lift_serial(lift_serial), .db_demand(db_demand),
    .run_internal(run_internal), .spd_ref_release(spd_ref_release),
    .brake_lift_req(brake_lift_req), .db_switch(db_switch),
    .fault_out(fault_out), .alarm_out(alarm_out),
    .curve_abort_en(curve_abort_en), .s_axi_bvalid(s_axi_bvalid));

// ### test/car_ctrl_model.sv
// Car controller model: run command and serial lift request
`timescale 1ns/1ps
module car_ctrl_model (
    // Clock and reset
    input  wire aclk,
    input  wire aresetn,
    // Bench commands
    input  wire go,
    input  wire keep_run,
    input  wire lift_cmd,
    // Drive side
    input  wire ramp_down_active,
    output reg  run_terminal,
    output reg  run_serial,
    output reg  lift_serial
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            run_terminal <= 1'b0;
            run_serial <= 1'b0;
            lift_serial <= 1'b0;
        end else begin
            // A careless controller drops run early when keep_run is low
            run_terminal <= go || (keep_run && run_terminal
                                   && ramp_down_active);
            run_serial <= go || (keep_run && run_serial
                                 && ramp_down_active);
            lift_serial <= lift_cmd;
        end
    end
endmodule

// ### test/test_drive_stop_brake_sequencer.sv
// Self-checking bench for the stop and brake sequencer
`timescale 1ns/1ps
module test_drive_stop_brake_sequencer;
    logic        aclk = 0, aresetn = 0, metric_units = 0;
    logic        ramp_down_active = 0, reg_release = 0, mag_current_ok = 0;
    logic        brake_lifted = 0, db_demand = 0, go = 0, keep_run = 1;
    logic        lift_cmd = 0, run_terminal, run_serial, lift_serial;
    logic        run_internal, spd_ref_release, brake_lift_req, db_switch;
    logic        fault_out, alarm_out, curve_abort_en, irq;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] exp_q[$];
    integer      err_total = 0, total_checks = 0, seed = 28202, i;

    always #2 aclk = ~aclk;

    drive_stop_brake_sequencer #(.DB_GRACE_CYCLES(32'd20))
        drive_stop_brake_sequencer_inst (
        .aclk(aclk), .aresetn(aresetn), .metric_units(metric_units),
        .run_terminal(run_terminal), .run_serial(run_serial),
        .ramp_down_active(ramp_down_active), .reg_release(reg_release),
        .mag_current_ok(mag_current_ok), .brake_lifted(brake_lifted),
        .lift_serial(lift_serial), .db_demand(db_demand),
        .run_internal(run_internal), .spd_ref_release(spd_ref_release),
        .brake_lift_req(brake_lift_req), .db_switch(db_switch),
        .fault_out(fault_out), .alarm_out(alarm_out),
        .curve_abort_en(curve_abort_en), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    car_ctrl_model car_ctrl_model_inst (
        .aclk(aclk), .aresetn(aresetn), .go(go), .keep_run(keep_run),
        .lift_cmd(lift_cmd), .ramp_down_active(ramp_down_active),
        .run_terminal(run_terminal), .run_serial(run_serial),
        .lift_serial(lift_serial));

    task automatic check(input [33:0] seen, input [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic pin(input logic seen, input logic exp);
        check({33'h0, seen}, {33'h0, exp});
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge aclk);
    endtask

    task give_verdict;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task wr(input [7:0] a, input [31:0] d);
        integer n;
        @(posedge aclk);
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 0;
        pin(s_axi_bvalid, 1'b1);
        check({32'h0, s_axi_bresp}, 34'h0);
    endtask

    task rd(input [7:0] a, input [33:0] exp);
        integer n;
        @(posedge aclk);
        n = 0;
        exp_q.push_back(exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 0;
        pin(s_axi_rvalid, 1'b1);
    endtask

    // Read results are compared against the oldest note
    always @(posedge aclk)
        if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());

    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        give_verdict;
    end

    initial begin
        cyc(2);
        aresetn <= 1;
        rd(8'h00, 34'h0);
        rd(8'h0c, 34'h0);
        rd(8'h10, {2'h2, 32'h0});
        for (i = 0; i < 3; i++) begin
            rnd = $random(seed);
            wr(8'h00, {29'h0, rnd[2], i[1:0]});
            cyc(2);
            pin(curve_abort_en, rnd[2]);
            rd(8'h00, {2'h0, 29'h0, rnd[2], i[1:0]});
            wr(8'h0c, {29'h0, rnd[5:3]});
            rd(8'h0c, {31'h0, rnd[5:3]});
        end
        // ----------------------------------------------------------
        // Reference gate and lift source
        // ----------------------------------------------------------
        wr(8'h00, 32'h0);
        reg_release <= 1;
        mag_current_ok <= 1;
        cyc(4);
        pin(spd_ref_release, 1'b1);
        pin(brake_lift_req, 1'b1);
        mag_current_ok <= 0;
        lift_cmd <= 1;
        cyc(4);
        pin(brake_lift_req, 1'b0);
        wr(8'h00, 32'h30);
        cyc(4);
        pin(spd_ref_release, 1'b0);
        pin(brake_lift_req, 1'b1);
        brake_lifted <= 1;
        cyc(4);
        pin(spd_ref_release, 1'b1);
        // ----------------------------------------------------------
        // Run held through ramp-down, stop interrupt
        // ----------------------------------------------------------
        wr(8'h00, 32'h1);
        wr(8'h0c, 32'h4);
        wr(8'h08, 32'h7);
        go <= 1;
        keep_run <= 0;
        cyc(5);
        pin(run_internal, 1'b1);
        ramp_down_active <= 1;
        go <= 0;
        cyc(5);
        pin(run_internal, 1'b1);
        ramp_down_active <= 0;
        cyc(5);
        pin(run_internal, 1'b0);
        pin(irq, 1'b1);
        wr(8'h08, 32'h4);
        cyc(3);
        pin(irq, 1'b0);
        // ----------------------------------------------------------
        // Braking switch grace, trip and guard kind
        // ----------------------------------------------------------
        for (i = 0; i < 2; i++) begin
            wr(8'h00, {28'h0, i[0], 3'h0});
            reg_release <= 1;
            db_demand <= 1;
            cyc(5);
            pin(db_switch, 1'b1);
            reg_release <= 0;
            cyc(12);
            pin(db_switch, 1'b1);
            cyc(20);
            pin(db_switch, 1'b0);
            pin(fault_out, !i[0]);
            pin(alarm_out, i[0]);
            rd(8'h08, {32'h0, i[0], !i[0]});
            wr(8'h08, 32'h7);
            reg_release <= 1;
            cyc(5);
            pin(fault_out, 1'b0);
        end
        db_demand <= 0;
        // ----------------------------------------------------------
        // Reset in mid-run with the metric strap set
        // ----------------------------------------------------------
        metric_units <= 1;
        aresetn <= 0;
        cyc(3);
        aresetn <= 1;
        pin(db_switch, 1'b0);
        cyc(6);
        pin(curve_abort_en, 1'b1);
        rd(8'h00, 34'h54);
        give_verdict;
    end
endmodule
